// file: fault_core.sv
// fault detection and response core with an APB register slave
`timescale 1ns/1ns
module fault_core (
	input  wire logic                ref_clk,
	input  wire logic                rst,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	input  wire logic                pump_undervolt_event,
	input  wire logic                supply_above_low,
	input  wire logic                supply_above_high,
	input  wire logic [5:0][7:0]     fet_current,
	input  wire logic                buck_hs_overcurrent,
	input  wire logic                buck_undervolt_event,
	input  wire logic [7:0]          csa_level,
	input  wire logic                temp_over_warning,
	input  wire logic                temp_below_warn_hys,
	input  wire logic                temp_over_shutdown,
	input  wire logic                temp_below_shut_hys,
	input  wire logic [2:0]          lock_cond,
	output logic                     fault_out_n,
	output fault_pkg::fet_state_t    fet_state,
	output logic                     pump_enable,
	output logic                     buck_fet_hiz,
	output logic                     reset_request
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0]           cfg;
		logic [31:0]           timing;
		logic [31:0]           levels;
		logic                  pready;
		logic [31:0]           prdata;
		logic                  pslverr;
		logic                  clr;
		logic [15:0]           tick_cnt;
		logic                  tick;
		fault_pkg::resp_t      ocp_st;
		fault_pkg::resp_t      ilim_st;
		fault_pkg::resp_t      ml_st;
		logic [7:0]            ocp_cnt;
		logic [7:0]            ilim_cnt;
		logic [7:0]            ml_cnt;
		logic                  otw_act;
		logic                  tsd_act;
		logic                  f_drv;
		logic                  f_pump;
		logic                  f_ovp;
		logic                  f_ocp;
		logic                  f_ot;
		logic                  f_otw;
		logic                  f_ots;
		logic                  f_ctrl;
		logic                  f_ilim;
		logic                  f_mlock;
		logic [2:0]            f_lock;
		logic [5:0]            f_fet;
		fault_pkg::fet_state_t fet;
		logic                  fault_n;
		logic                  pump_en;
		logic                  buck_hiz;
		logic                  reset_req;
	} core_state_t;

	core_state_t st_r;
	core_state_t st_nxt;

	// ----------------------------------------------------------------
	// deglitch filters: six FETs, buck high side, current limit
	// ----------------------------------------------------------------
	logic [7:0] qual;
	deglitch_if dg [fault_pkg::N_DEG] ();

	genvar gi;
	generate
		for (gi = 0; gi < fault_pkg::N_DEG; gi++)
		begin : g_deg
			if (gi < fault_pkg::N_FET)
			begin : g_fet
				assign dg[gi].cond  = fet_current[gi] >
					st_r.levels[fault_pkg::LEV_OCP +: 8];
				assign dg[gi].limit = st_r.timing[fault_pkg::TIM_OVERCURRENT_DEGLITCH +: 8];
			end
			else if (gi == fault_pkg::DEG_BUCK)
			begin : g_buck
				assign dg[gi].cond  = buck_hs_overcurrent;
				assign dg[gi].limit = st_r.timing[fault_pkg::TIM_OVERCURRENT_DEGLITCH +: 8];
			end
			else
			begin : g_ilim
				assign dg[gi].cond  = csa_level >
					st_r.levels[fault_pkg::LEV_ILIM +: 8];
				assign dg[gi].limit = st_r.timing[fault_pkg::TIM_ILIM_DEG +: 8];
			end
			deglitch_filter u_deg (
				.ref_clk (ref_clk),
				.rst     (rst),
				.port    (dg[gi])
			);
			assign qual[gi] = dg[gi].qualified;
		end
	endgenerate

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic fault_pkg::resp_t resp_step(input fault_pkg::resp_t cur,
		input logic latch_m, input logic retry_m, input logic ev,
		input logic clr, input logic expired);
		case (cur)
			fault_pkg::RESP_IDLE:
				if (ev && latch_m)
					resp_step = fault_pkg::RESP_LATCH;
				else if (ev && retry_m)
					resp_step = fault_pkg::RESP_RETRY;
				else
					resp_step = fault_pkg::RESP_IDLE;
			fault_pkg::RESP_LATCH:
				resp_step = (clr && !ev) ? fault_pkg::RESP_IDLE : fault_pkg::RESP_LATCH;
			fault_pkg::RESP_RETRY:
				resp_step = expired ? fault_pkg::RESP_IDLE : fault_pkg::RESP_RETRY;
			default:
				resp_step = fault_pkg::RESP_IDLE;
		endcase
	endfunction

	function automatic logic [7:0] retry_cnt(input fault_pkg::resp_t cur,
		input fault_pkg::resp_t nxt, input logic [7:0] cnt,
		input logic [7:0] load, input logic tick);
		if (cur != fault_pkg::RESP_RETRY && nxt == fault_pkg::RESP_RETRY)
			retry_cnt = (load == 8'h00) ? 8'h01 : load;
		else if (tick && cnt != 8'h00)
			retry_cnt = cnt - 8'h01;
		else
			retry_cnt = cnt;
	endfunction

	// set wins over clear
	function automatic logic sticky(input logic cur, input logic set, input logic clr);
		sticky = set || (cur && !clr);
	endfunction

	function automatic fault_pkg::fet_state_t fet_sel(input logic [1:0] low);
		case (low)
			2'h0:    fet_sel = fault_pkg::FET_ALL_OFF;
			2'h1:    fet_sel = fault_pkg::FET_RECIRC;
			2'h2:    fet_sel = fault_pkg::FET_HS_ON;
			default: fet_sel = fault_pkg::FET_LS_ON;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic [1:0] overcurrent_response_mode;
	logic [3:0] ilim_mode;
	logic [3:0] ml_mode;
	logic       ovp_cond;
	logic       ocp_on;
	logic       ocp_ev;
	logic       ilim_ev;
	logic       ml_ev;
	logic [2:0] lock_hit;
	logic       ocp_exp;
	logic       ilim_exp;
	logic       ml_exp;
	logic       access;
	logic       mapped;

	always_comb
	begin
		overcurrent_response_mode  = st_r.cfg[fault_pkg::CFG_OVERCURRENT_RESPONSE_MODE +: 2];
		ilim_mode = st_r.cfg[fault_pkg::CFG_ILIM_MODE +: 4];
		ml_mode   = st_r.cfg[fault_pkg::CFG_MLOCK_MODE +: 4];
		ovp_cond  = st_r.cfg[fault_pkg::CFG_OVERVOLT_PROTECT_ENABLE] &&
			(st_r.cfg[fault_pkg::CFG_OVERVOLT_THRESHOLD_SELECT] ? supply_above_high : supply_above_low);
		ocp_on    = overcurrent_response_mode != fault_pkg::OCP_OFF;
		ocp_ev    = ocp_on && (|qual[fault_pkg::N_FET-1:0]);
		ilim_ev   = qual[fault_pkg::DEG_ILIM] && !(ilim_mode[3] && ilim_mode[0]);
		lock_hit  = lock_cond & st_r.cfg[fault_pkg::CFG_LOCK_EN +: 3];
		ml_ev     = (|lock_hit) && !(ml_mode[3] && ml_mode[0]);
		ocp_exp   = st_r.ocp_st == fault_pkg::RESP_RETRY && st_r.ocp_cnt == 8'h00;
		ilim_exp  = st_r.ilim_st == fault_pkg::RESP_RETRY && st_r.ilim_cnt == 8'h00;
		ml_exp    = st_r.ml_st == fault_pkg::RESP_RETRY && st_r.ml_cnt == 8'h00;
		access    = psel && penable;
		mapped    = paddr == fault_pkg::REG_CONFIG || paddr == fault_pkg::REG_TIMING ||
			paddr == fault_pkg::REG_LEVELS || paddr == fault_pkg::REG_STATUS ||
			paddr == fault_pkg::REG_CONTROL;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;

		// apb: one wait state, completion on the edge where pready is high
		st_nxt.pready  = access && !st_r.pready;
		st_nxt.pslverr = access && !st_r.pready && !mapped;
		st_nxt.prdata  = 32'h0000_0000;
		if (access && !st_r.pready)
		begin
			case (paddr)
				fault_pkg::REG_CONFIG: st_nxt.prdata = st_r.cfg;
				fault_pkg::REG_TIMING: st_nxt.prdata = st_r.timing;
				fault_pkg::REG_LEVELS: st_nxt.prdata = st_r.levels;
				fault_pkg::REG_STATUS:
				begin
					st_nxt.prdata[fault_pkg::ST_DRV_FAULT]        = st_r.f_drv;
					st_nxt.prdata[fault_pkg::ST_PUMP_UV]          = st_r.f_pump;
					st_nxt.prdata[fault_pkg::ST_OVP]              = st_r.f_ovp;
					st_nxt.prdata[fault_pkg::ST_OCP]              = st_r.f_ocp;
					st_nxt.prdata[fault_pkg::ST_OT]               = st_r.f_ot;
					st_nxt.prdata[fault_pkg::ST_OTW]              = st_r.f_otw;
					st_nxt.prdata[fault_pkg::ST_OTS]              = st_r.f_ots;
					st_nxt.prdata[fault_pkg::ST_CTRL_FAULT]       = st_r.f_ctrl;
					st_nxt.prdata[fault_pkg::ST_ILIM]             = st_r.f_ilim;
					st_nxt.prdata[fault_pkg::ST_MLOCK]            = st_r.f_mlock;
					st_nxt.prdata[fault_pkg::ST_LOCK_COND +: 3]   = st_r.f_lock;
					st_nxt.prdata[fault_pkg::ST_FET_OCP +: 6]     = st_r.f_fet;
					st_nxt.prdata[fault_pkg::ST_FET_STATE +: 3]   = st_r.fet;
				end
				default: st_nxt.prdata = 32'h0000_0000;
			endcase
		end
		st_nxt.clr = 1'b0;
		if (access && st_r.pready && pwrite && !st_r.pslverr)
		begin
			case (paddr)
				fault_pkg::REG_CONFIG:  st_nxt.cfg    = pwdata;
				fault_pkg::REG_TIMING:  st_nxt.timing = pwdata;
				fault_pkg::REG_LEVELS:  st_nxt.levels = pwdata;
				fault_pkg::REG_CONTROL: st_nxt.clr    = pwdata[fault_pkg::CTL_CLEAR];
				default:                st_nxt.clr    = 1'b0;
			endcase
		end

		// retry time base
		st_nxt.tick     = st_r.tick_cnt == fault_pkg::RETRY_TICK_CYCLES - 16'h0001;
		st_nxt.tick_cnt = st_nxt.tick ? 16'h0000 : st_r.tick_cnt + 16'h0001;

		// response sequencers
		st_nxt.ocp_st  = resp_step(st_r.ocp_st, overcurrent_response_mode == fault_pkg::OCP_LATCH,
			overcurrent_response_mode == fault_pkg::OCP_RETRY, ocp_ev, st_r.clr, ocp_exp);
		st_nxt.ilim_st = resp_step(st_r.ilim_st, ilim_mode[3:2] == 2'h0,
			ilim_mode[3:2] == 2'h1, ilim_ev, st_r.clr, ilim_exp);
		st_nxt.ml_st   = resp_step(st_r.ml_st, ml_mode[3:2] == 2'h0,
			ml_mode[3:2] == 2'h1, ml_ev, st_r.clr, ml_exp);
		st_nxt.ocp_cnt  = retry_cnt(st_r.ocp_st, st_nxt.ocp_st, st_r.ocp_cnt,
			st_r.timing[fault_pkg::TIM_FET_RETRY +: 8], st_r.tick);
		st_nxt.ilim_cnt = retry_cnt(st_r.ilim_st, st_nxt.ilim_st, st_r.ilim_cnt,
			st_r.timing[fault_pkg::TIM_LOCK_RETRY_TIME +: 8], st_r.tick);
		st_nxt.ml_cnt   = retry_cnt(st_r.ml_st, st_nxt.ml_st, st_r.ml_cnt,
			st_r.timing[fault_pkg::TIM_LOCK_RETRY_TIME +: 8], st_r.tick);

		// thermal hysteresis
		st_nxt.otw_act = temp_over_warning || (st_r.otw_act && !temp_below_warn_hys);
		st_nxt.tsd_act = temp_over_shutdown || (st_r.tsd_act && !temp_below_shut_hys);

		// sticky flags
		st_nxt.f_pump = sticky(st_r.f_pump, pump_undervolt_event,
			st_r.clr && !pump_undervolt_event);
		st_nxt.f_ovp  = sticky(st_r.f_ovp, ovp_cond, st_r.clr && !ovp_cond);
		st_nxt.f_ocp  = sticky(st_r.f_ocp, ocp_ev, st_r.clr && !ocp_ev);
		for (int i = 0; i < fault_pkg::N_FET; i++)
			st_nxt.f_fet[i] = sticky(st_r.f_fet[i], ocp_on && qual[i],
				st_r.clr && !qual[i]);
		st_nxt.f_drv  = sticky(st_r.f_drv,
			pump_undervolt_event || ovp_cond || ocp_ev || st_r.tsd_act,
			(st_r.clr && !pump_undervolt_event && !ovp_cond && !ocp_ev && !st_r.tsd_act)
			|| ocp_exp);
		st_nxt.f_otw  = sticky(st_r.f_otw,
			st_r.otw_act && st_r.cfg[fault_pkg::CFG_THERMAL_WARNING_REPORT_ENABLE],
			st_r.clr && !st_r.otw_act);
		st_nxt.f_ots  = sticky(st_r.f_ots, st_r.tsd_act, st_r.clr && !st_r.tsd_act);
		st_nxt.f_ot   = sticky(st_r.f_ot,
			(st_r.otw_act && st_r.cfg[fault_pkg::CFG_THERMAL_WARNING_REPORT_ENABLE]) || st_r.tsd_act,
			st_r.clr && !st_r.otw_act && !st_r.tsd_act);
		st_nxt.f_ilim = sticky(st_r.f_ilim, ilim_ev,
			(st_r.clr && !ilim_ev) || ilim_exp);
		st_nxt.f_mlock = sticky(st_r.f_mlock, ml_ev, (st_r.clr && !ml_ev) || ml_exp);
		for (int i = 0; i < fault_pkg::N_LOCK; i++)
			st_nxt.f_lock[i] = sticky(st_r.f_lock[i], ml_ev && lock_hit[i],
				(st_r.clr && !lock_hit[i]) || ml_exp);
		st_nxt.f_ctrl = sticky(st_r.f_ctrl, ilim_ev || ml_ev,
			(st_r.clr && !ilim_ev && !ml_ev) || ilim_exp || ml_exp);

		// power stage control, shutdown causes first
		if (pump_undervolt_event || ovp_cond || st_r.tsd_act ||
			st_r.ocp_st != fault_pkg::RESP_IDLE)
			st_nxt.fet = fault_pkg::FET_ALL_OFF;
		else if (st_r.ilim_st != fault_pkg::RESP_IDLE)
			st_nxt.fet = fet_sel(ilim_mode[1:0]);
		else if (st_r.ml_st != fault_pkg::RESP_IDLE)
			st_nxt.fet = fet_sel(ml_mode[1:0]);
		else
			st_nxt.fet = fault_pkg::FET_NORMAL;
		st_nxt.fault_n = !(pump_undervolt_event || ovp_cond || st_r.tsd_act ||
			(st_r.otw_act && st_r.cfg[fault_pkg::CFG_THERMAL_WARNING_REPORT_ENABLE]) ||
			st_r.ocp_st != fault_pkg::RESP_IDLE || st_r.ilim_st != fault_pkg::RESP_IDLE ||
			st_r.ml_st != fault_pkg::RESP_IDLE);
		st_nxt.pump_en   = !st_r.tsd_act;
		st_nxt.buck_hiz  = qual[fault_pkg::DEG_BUCK] || buck_undervolt_event;
		st_nxt.reset_req = qual[fault_pkg::DEG_BUCK] || buck_undervolt_event;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			st_r         <= '0;
			st_r.cfg     <= fault_pkg::CONFIG_RESET;
			st_r.timing  <= fault_pkg::TIMING_RESET;
			st_r.levels  <= fault_pkg::LEVELS_RESET;
			st_r.ocp_st  <= fault_pkg::RESP_IDLE;
			st_r.ilim_st <= fault_pkg::RESP_IDLE;
			st_r.ml_st   <= fault_pkg::RESP_IDLE;
			st_r.fet     <= fault_pkg::FET_NORMAL;
			st_r.fault_n <= 1'b1;
			st_r.pump_en <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign pready        = st_r.pready;
	assign prdata        = st_r.prdata;
	assign pslverr       = st_r.pslverr;
	assign fault_out_n   = st_r.fault_n;
	assign fet_state     = st_r.fet;
	assign pump_enable   = st_r.pump_en;
	assign buck_fet_hiz  = st_r.buck_hiz;
	assign reset_request = st_r.reset_req;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_pump_fets_off: assert property (
		pump_undervolt_event |=> fet_state == fault_pkg::FET_ALL_OFF && !fault_out_n
			&& st_r.f_pump && st_r.f_drv)
		else $error("pump undervolt did not shut the stage");
	a_ovp_disabled: assert property (
		!st_r.cfg[fault_pkg::CFG_OVERVOLT_PROTECT_ENABLE] && !st_r.f_ovp |=> !st_r.f_ovp)
		else $error("overvolt flag set while protection off");
	a_ovp_high_trip: assert property (
		st_r.cfg[fault_pkg::CFG_OVERVOLT_PROTECT_ENABLE] && st_r.cfg[fault_pkg::CFG_OVERVOLT_THRESHOLD_SELECT]
			&& !supply_above_high && !st_r.f_ovp |=> !st_r.f_ovp)
		else $error("higher trip level fired below its limit");
	a_ocp_off_quiet: assert property (
		overcurrent_response_mode == fault_pkg::OCP_OFF && !st_r.f_ocp && !st_r.f_fet[0] |=> !st_r.f_ocp
			&& !st_r.f_fet[0])
		else $error("overcurrent flagged while disabled");
	a_ocp_latch_hold: assert property (
		st_r.ocp_st == fault_pkg::RESP_LATCH && !st_r.clr |=>
			st_r.ocp_st == fault_pkg::RESP_LATCH ##1 fet_state == fault_pkg::FET_ALL_OFF)
		else $error("latched overcurrent released without clear");
	a_tsd_pump_off: assert property (
		st_r.tsd_act |=> !pump_enable && fet_state == fault_pkg::FET_ALL_OFF)
		else $error("thermal shutdown left the pump running");
	a_clear_set_wins: assert property (
		st_r.clr && pump_undervolt_event |=> st_r.f_pump)
		else $error("clear dropped a live pump flag");
	a_buck_reset: assert property (
		buck_undervolt_event |=> buck_fet_hiz && reset_request)
		else $error("buck undervolt did not request reset");

endmodule // fault_core

// file: fault_pkg.sv
// constants and types shared by the fault response logic
package fault_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CONFIG  = 8'h00;
	localparam logic [7:0] REG_TIMING  = 8'h04;
	localparam logic [7:0] REG_LEVELS  = 8'h08;
	localparam logic [7:0] REG_STATUS  = 8'h0c;
	localparam logic [7:0] REG_CONTROL = 8'h10;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0001;
	localparam logic [31:0] TIMING_RESET = 32'h0a0a_0404;
	localparam logic [31:0] LEVELS_RESET = 32'h0000_c0c0;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CFG_OVERVOLT_PROTECT_ENABLE     = 0;
	localparam int CFG_OVERVOLT_THRESHOLD_SELECT    = 1;
	localparam int CFG_THERMAL_WARNING_REPORT_ENABLE    = 2;
	localparam int CFG_OVERCURRENT_RESPONSE_MODE   = 3;
	localparam int CFG_ILIM_MODE  = 8;
	localparam int CFG_MLOCK_MODE = 12;
	localparam int CFG_LOCK_EN    = 16;
	localparam int TIM_OVERCURRENT_DEGLITCH    = 0;
	localparam int TIM_ILIM_DEG   = 8;
	localparam int TIM_FET_RETRY  = 16;
	localparam int TIM_LOCK_RETRY_TIME  = 24;
	localparam int LEV_OCP        = 0;
	localparam int LEV_ILIM       = 8;
	localparam int ST_DRV_FAULT   = 0;
	localparam int ST_PUMP_UV     = 1;
	localparam int ST_OVP         = 2;
	localparam int ST_OCP         = 3;
	localparam int ST_OT          = 4;
	localparam int ST_OTW         = 5;
	localparam int ST_OTS         = 6;
	localparam int ST_CTRL_FAULT  = 8;
	localparam int ST_ILIM        = 9;
	localparam int ST_MLOCK       = 10;
	localparam int ST_LOCK_COND   = 11;
	localparam int ST_FET_OCP     = 16;
	localparam int ST_FET_STATE   = 24;
	localparam int CTL_CLEAR      = 0;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int N_FET    = 6;
	localparam int N_LOCK   = 3;
	localparam int N_DEG    = 8;
	localparam int DEG_BUCK = 6;
	localparam int DEG_ILIM = 7;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int              CLK_MHZ           = 25;
	localparam int              RETRY_TICK_US     = 100;
	localparam logic [15:0]     RETRY_TICK_CYCLES = 16'(RETRY_TICK_US * CLK_MHZ);

	// ----------------------------------------------------------------
	// modes and states
	// ----------------------------------------------------------------
	localparam logic [1:0] OCP_LATCH  = 2'h0;
	localparam logic [1:0] OCP_RETRY  = 2'h1;
	localparam logic [1:0] OCP_REPORT = 2'h2;
	localparam logic [1:0] OCP_OFF    = 2'h3;

	typedef enum logic [2:0] {
		FET_NORMAL  = 3'h0,
		FET_ALL_OFF = 3'h1,
		FET_RECIRC  = 3'h2,
		FET_HS_ON   = 3'h3,
		FET_LS_ON   = 3'h4
	} fet_state_t;

	typedef enum logic [1:0] {
		RESP_IDLE  = 2'h0,
		RESP_RETRY = 2'h1,
		RESP_LATCH = 2'h2
	} resp_t;

endpackage

// file: deglitch_if.sv
// link between the fault core and one deglitch filter
`timescale 1ns/1ns
interface deglitch_if;
	logic       cond;
	logic [7:0] limit;
	logic       qualified;

	modport filter (input cond, input limit, output qualified);
	modport user   (output cond, output limit, input qualified);
endinterface

// file: deglitch_filter.sv
// qualifies a raw comparator level held longer than a cycle limit
`timescale 1ns/1ns
module deglitch_filter (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	deglitch_if.filter        port
);

	typedef struct packed {
		logic [7:0] cnt;
		logic       q;
	} dg_state_t;

	dg_state_t st_r;
	dg_state_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (!port.cond)
		begin
			st_nxt.cnt = 8'h00;
			st_nxt.q   = 1'b0;
		end
		else if (st_r.cnt < port.limit)
		begin
			st_nxt.cnt = st_r.cnt + 8'h01;
			st_nxt.q   = 1'b0;
		end
		else
		begin
			st_nxt.q = 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign port.qualified = st_r.q;

	a_drop_clears: assert property (@(posedge ref_clk) disable iff (rst)
		!port.cond |=> !port.qualified)
		else $error("qualified level outlived its condition");
	a_needs_hold: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(port.qualified) |-> $past(port.cond) && $past(st_r.cnt) == $past(port.limit))
		else $error("qualified before the deglitch time ran out");

endmodule // deglitch_filter

// file: temp_sensor_model.sv
// die temperature sensor model feeding the thermal comparators
`timescale 1ns/1ns
module temp_sensor_model #(
	parameter logic [7:0] WARN = 8'h64,
	parameter logic [7:0] SHUT = 8'h96,
	parameter logic [7:0] HYS  = 8'h0a
) (
	input  wire logic [7:0] die_temp,
	output logic            over_warn,
	output logic            below_warn_hys,
	output logic            over_shut,
	output logic            below_shut_hys
);
	assign over_warn      = die_temp > WARN;
	assign below_warn_hys = die_temp < WARN - HYS;
	assign over_shut      = die_temp > SHUT;
	assign below_shut_hys = die_temp < SHUT - HYS;
endmodule // temp_sensor_model

// file: motor_driver_fault_response_test.sv
// self-checking bench for the fault response core
`timescale 1ns/1ns
module motor_driver_fault_response_test;
	logic                  ref_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0]            paddr = '0, csa_level = '0, die_temp = 8'h20;
	logic [31:0]           pwdata = '0, q, prdata;
	logic                  pump_undervolt_event = 1'h0, supply_above_low = 1'h0;
	logic                  supply_above_high = 1'h0, buck_hs_overcurrent = 1'h0;
	logic                  buck_undervolt_event = 1'h0, err, pready, pslverr, fault_out_n;
	logic                  pump_enable, buck_fet_hiz, reset_request, t_ow, t_wh, t_os, t_sh;
	logic [5:0][7:0]       fet_current = '0;
	logic [2:0]            lock_cond = '0;
	fault_pkg::fet_state_t fet_state;
	int                    fails = 0, total_checks = 0, cycles = 0;

	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			fails++;
			give_verdict();
		end
	end

	fault_core dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .pump_undervolt_event, .supply_above_low, .supply_above_high, .fet_current,
		.buck_hs_overcurrent, .buck_undervolt_event, .csa_level, .temp_over_warning(t_ow),
		.temp_below_warn_hys(t_wh), .temp_over_shutdown(t_os), .temp_below_shut_hys(t_sh),
		.lock_cond, .fault_out_n, .fet_state, .pump_enable, .buck_fet_hiz, .reset_request);
	temp_sensor_model sensor (.die_temp, .over_warn(t_ow), .below_warn_hys(t_wh),
		.over_shut(t_os), .below_shut_hys(t_sh));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		do
			@(posedge ref_clk);
		while (pready !== 1'h1);
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
	endtask

	task automatic w(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic clr();
		apb(1'h1, fault_pkg::REG_CONTROL, 32'h1);
		w(4);
	endtask

	task automatic cfg(input logic [31:0] d);
		apb(1'h1, fault_pkg::REG_CONFIG, d);
	endtask

	task automatic cs(input string nm, input logic [31:0] m, input logic [31:0] e);
		apb(1'h0, fault_pkg::REG_STATUS, '0);
		chk(nm, e, q & m);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		apb(1'h0, fault_pkg::REG_CONFIG, '0);
		chk("config", fault_pkg::CONFIG_RESET, q);
		apb(1'h0, fault_pkg::REG_TIMING, '0);
		chk("timing", fault_pkg::TIMING_RESET, q);
		apb(1'h0, 8'h40, '0);
		chk("unmapped err", 32'h1, {31'h0, err});
	endtask

	task automatic t_pump();
		pump_undervolt_event <= 1'h1;
		w(3);
		chk("pump fault", 32'h0, {31'h0, fault_out_n});
		chk("pump fet", 32'h1, {29'h0, fet_state});
		clr();
		cs("pump set wins", 32'h2, 32'h2);
		pump_undervolt_event <= 1'h0;
		w(3);
		chk("pump resume", 32'h1, {31'h0, fault_out_n});
		apb(1'h0, fault_pkg::REG_STATUS, '0);
		chk("pump flag", 32'h1, {31'h0, q[1]});
		clr();
		apb(1'h0, fault_pkg::REG_STATUS, '0);
		chk("pump flag clr", 32'h0, {31'h0, q[1]});
	endtask

	task automatic t_ovp();
		supply_above_low <= 1'h1;
		w(3);
		chk("ovp low", 32'h0, {31'h0, fault_out_n});
		apb(1'h1, fault_pkg::REG_CONFIG, 32'h3);
		w(3);
		chk("ovp high sel", 32'h1, {31'h0, fault_out_n});
		apb(1'h1, fault_pkg::REG_CONFIG, 32'h0);
		supply_above_high <= 1'h1;
		w(3);
		chk("ovp off", 32'h1, {31'h0, fault_out_n});
		supply_above_low <= 1'h0;
		supply_above_high <= 1'h0;
		apb(1'h1, fault_pkg::REG_CONFIG, 32'h1);
		clr();
	endtask

	task automatic t_ocp();
		fet_current[2] <= 8'hc0;
		w(12);
		chk("ocp at level", 32'h0, {29'h0, fet_state});
		fet_current[2] <= 8'hc1;
		w(12);
		chk("ocp latch", 32'h1, {29'h0, fet_state});
		fet_current[2] <= 8'h00;
		w(12);
		apb(1'h0, fault_pkg::REG_STATUS, '0);
		chk("ocp fet flag", 32'h1, {31'h0, q[18]});
		chk("ocp held", 32'h1, {29'h0, fet_state});
		clr();
		chk("ocp cleared", 32'h0, {29'h0, fet_state});
	endtask

	task automatic t_ilim();
		logic [3:0] m;
		for (int k = 0; k < 5; k++)
		begin
			m = (k == 4) ? 4'h9 : 4'(k);
			apb(1'h1, fault_pkg::REG_CONFIG, {20'h0, m, 8'h01});
			csa_level <= 8'hc1;
			w(12);
			chk("ilim fet", (k == 4) ? 32'h0 : 32'(k + 1), {29'h0, fet_state});
			csa_level <= 8'h00;
			clr();
			chk("ilim resume", 32'h0, {29'h0, fet_state});
		end
		apb(1'h1, fault_pkg::REG_CONFIG, 32'h1);
	endtask

	task automatic t_ocp_modes();
		apb(1'h1, fault_pkg::REG_TIMING, 32'h0202_0404);
		cfg(32'h9);
		fet_current[0] <= 8'hc1;
		w(12);
		chk("ocp retry", 32'h0, {31'h0, fault_out_n});
		fet_current[0] <= 8'h00;
		w(5200);
		chk("ocp resumed", 32'h0, {29'h0, fet_state});
		cs("ocp retry flags", 32'h9, 32'h8);
		clr();
		cfg(32'h11);
		fet_current[0] <= 8'hc1;
		w(12);
		chk("ocp report", 32'h0, {29'h0, fet_state});
		cs("ocp report flags", 32'h1_0009, 32'h1_0009);
		fet_current[0] <= 8'h00;
		clr();
		cs("ocp report clr", 32'h1_0009, 32'h0);
		cfg(32'h19);
		fet_current[0] <= 8'hc1;
		w(12);
		cs("ocp off flags", 32'h1_0009, 32'h0);
		fet_current[0] <= 8'h00;
	endtask

	task automatic t_lim_modes();
		cfg(32'h401);
		csa_level <= 8'hc1;
		w(12);
		chk("ilim retry", 32'h1, {29'h0, fet_state});
		csa_level <= 8'h00;
		w(5200);
		cs("ilim retry flags", 32'h300, 32'h0);
		cfg(32'h801);
		csa_level <= 8'hc1;
		w(12);
		cs("ilim report", 32'h300, 32'h300);
		csa_level <= 8'h00;
		clr();
	endtask

	task automatic t_lock();
		cfg(32'h1_3001);
		lock_cond <= 3'h2;
		w(4);
		chk("lock masked", 32'h0, {29'h0, fet_state});
		lock_cond <= 3'h1;
		w(4);
		chk("lock latch", 32'h4, {29'h0, fet_state});
		cs("lock latch flags", 32'h3f00, 32'hd00);
		lock_cond <= 3'h0;
		clr();
		chk("lock clr", 32'h0, {29'h0, fet_state});
		cfg(32'h1_4001);
		lock_cond <= 3'h1;
		w(4);
		chk("lock retry", 32'h1, {29'h0, fet_state});
		lock_cond <= 3'h0;
		w(5200);
		cs("lock retry flags", 32'h3f00, 32'h0);
		cfg(32'h1_8001);
		lock_cond <= 3'h1;
		w(4);
		cs("lock report", 32'h3f00, 32'hd00);
		lock_cond <= 3'h0;
		clr();
		cfg(32'h1_9001);
		lock_cond <= 3'h1;
		w(4);
		cs("lock off", 32'h3f00, 32'h0);
		lock_cond <= 3'h0;
	endtask

	task automatic t_warn();
		cfg(32'h5);
		die_temp <= 8'h70;
		w(4);
		chk("warn fault", 32'h0, {31'h0, fault_out_n});
		die_temp <= 8'h20;
		w(4);
		chk("warn release", 32'h1, {31'h0, fault_out_n});
		cs("warn flags", 32'h30, 32'h30);
		clr();
		cs("warn flag clr", 32'h20, 32'h0);
		cfg(32'h1);
	endtask

	task automatic t_heat();
		die_temp <= 8'hff;
		w(4);
		chk("shut pump", 32'h0, {31'h0, pump_enable});
		die_temp <= 8'h20;
		w(4);
		chk("shut resume", 32'h1, {31'h0, fault_out_n});
		apb(1'h0, fault_pkg::REG_STATUS, '0);
		chk("shut flag", 32'h1, {31'h0, q[6]});
		buck_undervolt_event <= 1'h1;
		w(3);
		chk("buck_undervolt_event", 32'h1, {31'h0, reset_request});
		buck_undervolt_event <= 1'h0;
		buck_hs_overcurrent <= 1'h1;
		w(12);
		chk("buck oc", 32'h1, {31'h0, buck_fet_hiz});
		buck_hs_overcurrent <= 1'h0;
	endtask

	task give_verdict();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'h0;
		w(2);
		t_regs();
		t_pump();
		t_ovp();
		t_ocp();
		t_ilim();
		t_ocp_modes();
		t_lim_modes();
		t_lock();
		t_warn();
		t_heat();
		give_verdict();
	end
endmodule // motor_driver_fault_response_test
